// file: rtl/dtr_digit_out.sv
// Digit code, valid flag and timebase logic of the tone receiver
`timescale 1ns/1ps
module dtr_digit_out
   import dtr_pkg::*;
#(
   parameter logic [CNT_W-1:0] DV_FALL_CNT = DV_FALL_CYC,
   parameter logic [CNT_W-1:0] OVERLAP_CNT = OVERLAP_CYC
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Detector front end
   input wire dtr_tone_t tone_i,
   // Control pins
   input wire logic code_format_select_i,
   input wire logic column3_inhibit_i,
   input wire logic output_enable_i,
   input wire logic digit_valid_clear_i,
   // Code and flag pins
   output logic [3:0] code_o,
   output logic code_oe_n_o,
   output logic digit_valid_flag_o,
   // Oscillator and shared timebase
   input wire logic crystal_osc_enable_i,
   input wire logic osc_input_i,
   output logic osc_output_o,
   input wire logic shared_timebase_clock_i,
   output logic shared_timebase_clock_o,
   output logic shared_timebase_clock_oe_n_o,
   output logic timebase_o,
   // Register port
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o
);

   dtr_state_t state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [3:0] code_q, code_d;
   logic dv_q, dv_d;
   logic clr_q;
   logic tb_q;
   logic [31:0] rdata_q;

   // Decode
   wire logic clr_rise = digit_valid_clear_i & ~clr_q;
   wire logic soft_clr = wr_i & (addr_i == REG_CTRL) & wdata_i[CTRL_CLR_BIT];
   wire logic drop_dv = clr_rise | soft_clr;
   // Column 3 pairs are dropped while inhibited
   wire logic col3_blocked = column3_inhibit_i & (tone_i.col == COL_INHIBIT);
   wire logic accept = tone_i.valid & ~col3_blocked;
   // Row-major keypad index gives both the matrix and the frequency pair
   wire logic [3:0] key_idx = {tone_i.row, tone_i.col};
   wire logic [3:0] hex_code = HEX_LUT[{key_idx, 2'b00} +: 4];
   wire logic [3:0] b28_code = {tone_i.row, tone_i.col};
   wire logic [3:0] new_code =
      code_format_select_i ? hex_code : b28_code;
   // Counters end one short, so each parameter is the full span in cycles
   wire logic pause_done = (cnt_q == DV_FALL_CNT - CNT_W'(1));
   wire logic overlap_done = (cnt_q == OVERLAP_CNT - CNT_W'(1));
   wire logic busy = (state_q != DTR_IDLE);
   // Status fields placed at their package positions
   wire logic [31:0] st_code = 32'(code_q) << ST_CODE_LSB;
   wire logic [31:0] st_dv = 32'(dv_q) << ST_DV_BIT;
   wire logic [31:0] st_busy = 32'(busy) << ST_BUSY_BIT;
   wire logic [31:0] status_word = st_code | st_dv | st_busy;
   // Unmapped addresses read as zero
   wire logic [31:0] rd_mux = (addr_i == REG_STATUS) ? status_word : 32'h0;

   // Sequencer; a new pair is only looked at in idle
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      code_d = code_q;
      dv_d = dv_q;
      // A clear only lowers a flag that is up; the load step below sets
      // it again, so a digit is never lost to a clear in the same cycle
      if (drop_dv) begin
         dv_d = 1'b0;
      end
      unique case (state_q)
         DTR_IDLE: begin
            if (accept) begin
               code_d = new_code;
               state_d = DTR_LOAD;
            end
         end
         DTR_LOAD: begin
            // Flag one cycle after the code so the bus sees stable data
            dv_d = 1'b1;
            state_d = DTR_TONE;
         end
         DTR_TONE: begin
            cnt_d = '0;
            if (!tone_i.present) begin
               state_d = DTR_PAUSE;
            end
         end
         DTR_PAUSE: begin
            if (tone_i.present) begin
               // Pause broken by the tone returning: time it again
               cnt_d = '0;
               state_d = DTR_TONE;
            end else if (pause_done) begin
               dv_d = 1'b0;
               cnt_d = '0;
               state_d = DTR_OVERLAP;
            end else begin
               cnt_d = cnt_q + CNT_W'(1);
            end
         end
         DTR_OVERLAP: begin
            if (overlap_done) begin
               code_d = CODE_RST;
               cnt_d = '0;
               state_d = DTR_IDLE;
            end else begin
               cnt_d = cnt_q + CNT_W'(1);
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_q <= DTR_IDLE;
         cnt_q <= '0;
         code_q <= CODE_RST;
         dv_q <= 1'b0;
         clr_q <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         code_q <= code_d;
         dv_q <= dv_d;
         clr_q <= digit_valid_clear_i;
         rdata_q <= rd_i ? rd_mux : 32'h0;
      end
   end

   // Timebase divider; only a crude stand-in for the crystal inverter
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         tb_q <= 1'b0;
      end else begin
         tb_q <= crystal_osc_enable_i ? ~tb_q : 1'b0;
      end
   end

   assign code_o = code_q;
   // The pad floats the code pins while the enable input is low
   assign code_oe_n_o = ~output_enable_i;
   assign digit_valid_flag_o = dv_q;
   assign rdata_o = rdata_q;
   assign osc_output_o = crystal_osc_enable_i & ~osc_input_i;
   assign shared_timebase_clock_o = tb_q;
   assign shared_timebase_clock_oe_n_o = ~crystal_osc_enable_i;
   // A slave takes its timing from the shared pin
   assign timebase_o =
      crystal_osc_enable_i ? tb_q : shared_timebase_clock_i;

   // Checks
   a_dv_after_code: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) $rose(dv_q) |-> $past(state_q) == DTR_LOAD
         && $stable(code_q))
      else $error("flag rose without code loaded first");

   a_inhibit_col_three: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) state_q == DTR_IDLE && tone_i.valid
         && column3_inhibit_i && tone_i.col == COL_INHIBIT
         |=> state_q == DTR_IDLE)
      else $error("inhibited column 3 pair accepted");

   a_clear_drops_dv: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) clr_rise && state_q != DTR_LOAD |=> !dv_q)
      else $error("clear edge did not drop the flag");

   a_output_enable: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) code_oe_n_o == !output_enable_i)
      else $error("code pin enable does not follow input");

   a_hex_code_map: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) state_q == DTR_IDLE && accept
         && code_format_select_i
         |=> code_q == HEX_LUT[{$past(key_idx), 2'b00} +: 4])
      else $error("hex code wrong");

   a_b28_code_map: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) state_q == DTR_IDLE && accept
         && !code_format_select_i
         |=> code_q == {$past(tone_i.row), $past(tone_i.col)})
      else $error("2-of-8 code wrong");

   sequence s_pause_end;
      state_q == DTR_PAUSE && !tone_i.present && pause_done;
   endsequence

   a_dv_fall_time: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) s_pause_end |=> !dv_q && state_q == DTR_OVERLAP
         && cnt_q == '0)
      else $error("flag did not fall at end of pause");

   a_code_hold_clear: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) state_q == DTR_OVERLAP && overlap_done
         |=> code_q == CODE_RST && state_q == DTR_IDLE)
      else $error("code not cleared after hold time");

   a_no_new_digit: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) state_q == DTR_PAUSE || state_q == DTR_OVERLAP
         |=> state_q != DTR_LOAD && $stable(code_q) || state_q == DTR_IDLE)
      else $error("new digit taken before pause timed");

   a_dv_held_tone: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) dv_q && state_q == DTR_TONE && !drop_dv
         |=> dv_q)
      else $error("flag dropped while tone held");

   a_timebase_drive: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) crystal_osc_enable_i
         |-> !shared_timebase_clock_oe_n_o)
      else $error("master not driving timebase");

   a_set_wins: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) state_q == DTR_LOAD |=> dv_q)
      else $error("flag not set after code load");

   sequence s_digit_taken;
      state_q == DTR_IDLE && accept;
   endsequence

   sequence s_flag_after_load;
      state_q == DTR_LOAD ##1 state_q == DTR_TONE && dv_q;
   endsequence

   // Code first, flag one cycle later
   a_digit_handover: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) s_digit_taken |=> s_flag_after_load)
      else $error("digit not handed over code first");

   a_code_stable_flag: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) dv_q |=> $stable(code_q))
      else $error("code changed while flag high");

   a_idle_code_clear: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) state_q == DTR_IDLE
         |-> code_q == CODE_RST && !dv_q)
      else $error("code or flag left over in idle");

   a_ignore_busy: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) state_q != DTR_IDLE |=> state_q != DTR_LOAD)
      else $error("digit taken while busy");

   // Only a timed pause or a clear may lower the flag
   a_dv_fall_cause: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) $fell(dv_q) |-> $past(drop_dv)
         || $past(state_q) == DTR_PAUSE && $past(pause_done))
      else $error("flag fell without pause or clear");

   a_pause_restart: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) state_q == DTR_PAUSE && tone_i.present
         |=> state_q == DTR_TONE && cnt_q == '0)
      else $error("returning tone did not restart the pause");

   a_pause_count_bound: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) state_q == DTR_PAUSE |-> cnt_q < DV_FALL_CNT)
      else $error("pause counter ran past its end");

   a_overlap_bound: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) state_q == DTR_OVERLAP
         |-> cnt_q < OVERLAP_CNT && !dv_q)
      else $error("hold counter ran past its end");

   // Skip the first edge after reset, where the divider was held
   a_timebase_toggle: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) !$past(rst_i) && $past(crystal_osc_enable_i)
         |-> shared_timebase_clock_o != $past(shared_timebase_clock_o))
      else $error("master timebase not toggling");

   a_timebase_idle: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) !$past(crystal_osc_enable_i)
         |-> !shared_timebase_clock_o)
      else $error("idle timebase output not low");

   // Read data stand for one cycle only, zero otherwise
   a_rdata_one_cycle: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) !$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside their cycle");

endmodule // dtr_digit_out

// file: rtl/dtr_pkg.sv
// Package for the tone receiver digit output stage
package dtr_pkg;
   // Clock rate and counter width
   localparam int CLK_MHZ = 40;
   localparam int CNT_W = 21;
   // Tone end to flag fall, microseconds (window 40000..50000)
   localparam int DV_FALL_US = 45000;
   // Data hold after flag fall, microseconds (window 4000..4800)
   localparam int OVERLAP_US = 4400;
   localparam logic [CNT_W-1:0] DV_FALL_CYC = CNT_W'(DV_FALL_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] OVERLAP_CYC = CNT_W'(OVERLAP_US * CLK_MHZ);
   // Column of the 1633 Hz tone
   localparam logic [1:0] COL_INHIBIT = 2'h3;
   // Hex code per keypad position, nibble index = row*4 + col
   localparam logic [63:0] HEX_LUT = 64'h0CABF987E654D321;
   // Register offsets, fields and reset values
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_CTRL = 4'h4;
   localparam int ST_CODE_LSB = 0;
   localparam int ST_DV_BIT = 4;
   localparam int ST_BUSY_BIT = 5;
   localparam int CTRL_CLR_BIT = 0;
   localparam logic [3:0] CODE_RST = 4'h0;

   typedef enum {
      DTR_IDLE, DTR_LOAD, DTR_TONE, DTR_PAUSE, DTR_OVERLAP
   } dtr_state_t;

   // Tone pair as reported by the detector front end
   typedef struct packed {
      logic valid;
      logic present;
      logic [1:0] row;
      logic [1:0] col;
   } dtr_tone_t;
endpackage

// file: test/dtr_host_model.sv
// Host side model that latches each digit and can clear the flag
`timescale 1ns/1ps
module dtr_host_model
   import dtr_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Receiver pins
   input wire logic flag_i,
   input wire logic [3:0] code_i,
   // Test control
   input wire logic auto_clr_i,
   output logic [3:0] got_o,
   output logic clr_o
);
   logic flag_q;
   logic [1:0] wait_q;
   always_ff @(posedge ref_clk_i) begin
      flag_q <= flag_i;
      clr_o <= 1'b0;
      if (rst_i) begin
         got_o <= 4'h0;
         wait_q <= 2'h0;
      end else if (flag_i && !flag_q) begin
         got_o <= code_i;
         wait_q <= auto_clr_i ? 2'h3 : 2'h0;
      end else if (wait_q != 2'h0) begin
         // Single pulse, so the receiver sees a clean rising edge
         wait_q <= wait_q - 2'h1;
         clr_o <= (wait_q == 2'h1);
      end
   end
endmodule // dtr_host_model

// file: test/tb.sv
// Self-checking bench for the digit output stage
`timescale 1ns/1ps
module tb;
   import dtr_pkg::*;
   localparam int DV = 20;
   localparam int OV = 8;
   logic ref_clk_i = 1'b0, rst_i = 1'b1, auto_clr = 1'b0, tb1, tb2;
   dtr_tone_t tone_i = '0;
   logic code_format_select_i = 1'b1, column3_inhibit_i = 1'b0;
   logic output_enable_i = 1'b1, digit_valid_clear_i;
   logic crystal_osc_enable_i = 1'b0, osc_input_i = 1'b1;
   logic shared_timebase_clock_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [3:0] addr_i = 4'h0, code_o, got;
   logic [31:0] wdata_i = 32'h0, rdata_o;
   logic code_oe_n_o, digit_valid_flag_o, osc_output_o, timebase_o;
   logic shared_timebase_clock_o, shared_timebase_clock_oe_n_o;
   int bad_count = 0, check_count = 0;
   // Expected hex code per keypad position, index row*4+col
   logic [3:0] hx [16] = '{4'h1, 4'h2, 4'h3, 4'hD, 4'h4, 4'h5, 4'h6,
      4'hE, 4'h7, 4'h8, 4'h9, 4'hF, 4'hB, 4'hA, 4'hC, 4'h0};
   always #12.5 ref_clk_i = ~ref_clk_i;
   dtr_digit_out #(.DV_FALL_CNT(21'(DV)), .OVERLAP_CNT(21'(OV)))
      dtr_digit_out_inst (.ref_clk_i, .rst_i, .tone_i,
      .code_format_select_i, .column3_inhibit_i, .output_enable_i,
      .digit_valid_clear_i, .code_o, .code_oe_n_o, .digit_valid_flag_o,
      .crystal_osc_enable_i, .osc_input_i, .osc_output_o,
      .shared_timebase_clock_i, .shared_timebase_clock_o,
      .shared_timebase_clock_oe_n_o, .timebase_o, .addr_i, .wdata_i,
      .wr_i, .rd_i, .rdata_o);
   dtr_host_model dtr_host_model_inst (.ref_clk_i, .rst_i,
      .flag_i(digit_valid_flag_o), .code_i(code_o), .auto_clr_i(auto_clr),
      .got_o(got), .clr_o(digit_valid_clear_i));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      @(negedge ref_clk_i);
      chk("rdata", e, rdata_o);
   endtask
   task automatic pulse(input logic [1:0] r, c);
      @(posedge ref_clk_i);
      tone_i <= '{1'b1, 1'b1, r, c};
      @(posedge ref_clk_i);
      tone_i.valid <= 1'b0;
      @(negedge ref_clk_i);
   endtask
   task automatic digit(input logic [1:0] r, c, input logic f, clr);
      logic [3:0] e;
      int n;
      e = f ? hx[{r, c}] : {r, c};
      @(posedge ref_clk_i);
      code_format_select_i <= f;
      auto_clr <= clr;
      pulse(r, c);
      chk("code", e, code_o);
      chk("early flag", 0, digit_valid_flag_o);
      @(negedge ref_clk_i);
      chk("flag", 1, digit_valid_flag_o);
      if (clr) begin
         repeat (5) @(negedge ref_clk_i);
         chk("cleared flag", 0, digit_valid_flag_o);
         pulse(~r, ~c);
         repeat (3) @(negedge ref_clk_i);
         chk("held code", e, code_o);
         chk("no reraise", 0, digit_valid_flag_o);
      end
      @(posedge ref_clk_i);
      tone_i.present <= 1'b0;
      n = 0;
      do begin
         @(negedge ref_clk_i);
         n++;
      end while (digit_valid_flag_o === 1'b1 && n < 60);
      if (clr) repeat (DV) @(negedge ref_clk_i);
      if (!clr) chk("host", e, got);
      if (!clr) chk("fall time", 1, n >= 19 && n <= 24);
      repeat (OV - 2) @(negedge ref_clk_i);
      chk("overlap", e, code_o);
      repeat (6) @(negedge ref_clk_i);
      chk("pause clear", 0, code_o);
   endtask
   initial begin
      #(25 * 20000);
      bad_count++;
      end_of_test();
   end
   initial begin
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(negedge ref_clk_i);
      chk("reset flag", 0, digit_valid_flag_o);
      chk("reset code", CODE_RST, code_o);
      for (int i = 0; i < 32; i++) digit(i[3:2], i[1:0], i[4], 1'b0);
      digit(2'h1, 2'h2, 1'b1, 1'b1);
      $display("digit tests done");
      @(posedge ref_clk_i);
      column3_inhibit_i <= 1'b1;
      auto_clr <= 1'b0;
      pulse(2'h2, 2'h3);
      repeat (3) @(negedge ref_clk_i);
      chk("inhibit", 0, {code_o, digit_valid_flag_o});
      @(posedge ref_clk_i);
      column3_inhibit_i <= 1'b0;
      tone_i.present <= 1'b0;
      pulse(2'h0, 2'h1);
      rd(4'h0, {26'h0, 2'h3, 4'h2});
      rd(4'h8, 32'h0);
      rd(4'h4, 32'h0);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      wdata_i <= 32'h1;
      addr_i <= 4'h4;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
      @(negedge ref_clk_i);
      chk("soft clear", 0, digit_valid_flag_o);
      chk("code kept", 4'h2, code_o);
      @(posedge ref_clk_i);
      tone_i.present <= 1'b0;
      repeat (DV + OV + 10) @(negedge ref_clk_i);
      rd(4'h0, 32'h0);
      $display("register tests done");
      // One receiver on the shared pin, far inside the fan-out limit
      for (int i = 0; i < 8; i++) begin
         @(posedge ref_clk_i);
         {output_enable_i, crystal_osc_enable_i, osc_input_i} <= i[2:0];
         shared_timebase_clock_i <= i[2];
         @(negedge ref_clk_i);
         chk("code oe", !i[2], code_oe_n_o);
         chk("osc out", i[1] & !i[0], osc_output_o);
         chk("tb oe", !i[1], shared_timebase_clock_oe_n_o);
         tb1 = timebase_o;
         @(negedge ref_clk_i);
         tb2 = timebase_o;
         // Master toggles every cycle, slave follows the shared pin
         chk("timebase", i[1] ? !tb1 : i[2], tb2);
         chk("tb drive", i[1] & tb2, shared_timebase_clock_o);
      end
      $display("pin tests done");
      end_of_test();
   end
endmodule // tb
